// ===== pkg/fbas_pkg.sv
/*
 * Shared constants, types and helpers for the station address and write lock
 * select block: register map, field positions, timing counts, state types.
 * Assumes a single 40 MHz clock and a switch bank already synchronous to it.
 */
// Functional notes
// - Station address is sum of switch weights
// - Every switch on means function enabled
// - Write lock on rejects configuration writes
// - Lock state readable and key indicator shown
// - Valid addresses 0 to 125, unique
// - Service address 126, factory telegram mode
// - Mode on to off: restart, switch address
// - Switch address change: restart after 10 s
// - Switch mode refuses address-change telegram
// - Mode off to on: restart at 126
// - Telegram mode accepts address-change telegram
// - Telegram mode ignores address switch changes
// - Switch address above 125 acts as telegram
// - Invalid to valid switch address: restart, adopt
// - Simulation switch disables fieldbus communication
// - Configuration-locked indicator while lock active
package fbas_pkg;

    localparam int ADDR_W = 7;
    localparam logic [6:0] ADDR_MAX_VALID = 7'h7D;
    localparam logic [6:0] ADDR_SERVICE = 7'h7E;

    // Restart delay, derived from the clock rate
    localparam int CLK_HZ = 40000000;
    localparam int RESTART_MS = 10000;
    localparam int RESTART_CYCLES = (CLK_HZ / 1000) * RESTART_MS;

    // Avalon-MM register map, byte addresses
    localparam int BUS_AW = 5;
    localparam logic [4:0] REG_STATUS = 5'h00;
    localparam logic [4:0] REG_STATION = 5'h04;
    localparam logic [4:0] REG_ADDR_CMD = 5'h08;
    localparam logic [4:0] REG_CONFIG = 5'h0C;
    localparam logic [4:0] REG_FLAGS = 5'h10;

    // STATUS fields
    localparam int ST_TELEGRAM_BIT = 0;
    localparam int ST_SIMULATION_BIT = 1;
    localparam int ST_LOCK_BIT = 2;
    localparam int ST_PENDING_BIT = 3;
    localparam int ST_COMM_BIT = 4;
    localparam int ST_SW_ADDR_LSB = 8;
    localparam int ST_SW_MODE_BIT = 15;

    // STATION fields
    localparam int STN_VALID_BIT = 8;

    // FLAGS fields, write one to clear
    localparam int FL_TEL_REFUSED_BIT = 0;
    localparam int FL_CFG_REFUSED_BIT = 1;
    localparam int FL_W = 2;

    localparam int CONFIG_W = 16;
    localparam logic [15:0] CONFIG_RST = 16'h0000;

    // Switch bank as seen on the electronics module
    typedef struct packed {
        logic [6:0] addr;
        logic telegram_mode;
        logic simulation_switch;
        logic write_lock;
    } fbas_switch_type;

    typedef enum logic [1:0] {PH_INIT, PH_RUN, PH_WAIT} fbas_phase_type;

    typedef struct packed {
        logic [6:0] seen_addr;
        logic seen_mode;
        logic [6:0] sw_addr;
        logic target_tel;
        logic change;
        logic ready;
    } fbas_watch_type;

    typedef struct packed {
        logic [31:0] count;
        logic busy;
        logic done;
    } fbas_timer_type;

    // Binary-weighted sum of the address switches, weights 1 to 64
    function automatic logic [6:0] fbas_weight_sum(input logic [6:0] sw);
        logic [6:0] sum;
        sum = 7'h00;
        for (int i = 0; i < ADDR_W; i++)
        begin
            if (sw[i])
                sum = sum + 7'(1 << i);
        end
        return sum;
    endfunction

endpackage

// ===== logic/fbas_timer.sv
/*
 * Retriggerable one-shot delay counter for the restart delay.
 * Assumes start is a one-cycle pulse; a new start reloads the full delay.
 */
`timescale 1ns/1ps
`default_nettype none
module fbas_timer #(
    parameter int CYCLES = fbas_pkg::RESTART_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    output logic busy,
    output logic done
);

    fbas_pkg::fbas_timer_type s_q;
    fbas_pkg::fbas_timer_type s_d;

    // Reload on start, otherwise count down and pulse at the end
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start)
        begin
            s_d.count = 32'(CYCLES);
            s_d.busy = 1'b1;
        end
        else if (s_q.busy)
        begin
            if (s_q.count <= 32'h00000001)
            begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
            else
                s_d.count = s_q.count - 32'h00000001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign busy = s_q.busy;
    assign done = s_q.done;

endmodule
`default_nettype wire

// ===== logic/fbas_watch.sv
/*
 * Switch bank watcher: weighs the address switches, works out the addressing
 * that a restart would select, and flags changes that must lead to a restart.
 * Assumes the switch inputs are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module fbas_watch (
    input wire logic clk,
    input wire logic srst,
    input wire fbas_pkg::fbas_switch_type sw,
    output logic [6:0] sw_addr,
    output logic target_tel,
    output logic change,
    output logic ready
);

    fbas_pkg::fbas_watch_type s_q;
    fbas_pkg::fbas_watch_type s_d;
    logic [6:0] weighed;

    // Address switches ignored while telegram mode is selected
    always_comb
    begin
        weighed = fbas_pkg::fbas_weight_sum(sw.addr);
        s_d = s_q;
        s_d.seen_addr = sw.addr;
        s_d.seen_mode = sw.telegram_mode;
        s_d.sw_addr = weighed;
        s_d.target_tel = sw.telegram_mode || (weighed > fbas_pkg::ADDR_MAX_VALID);
        s_d.change = s_q.ready && ((sw.telegram_mode != s_q.seen_mode)
            || (!sw.telegram_mode && (sw.addr != s_q.seen_addr)));
        s_d.ready = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign sw_addr = s_q.sw_addr;
    assign target_tel = s_q.target_tel;
    assign change = s_q.change;
    assign ready = s_q.ready;

endmodule
`default_nettype wire

// ===== logic/fbas_select.sv
/*
 * Station address and write lock select, top level.
 * Picks the station address from the switch bank or from address-change
 * telegrams, schedules delayed restarts, applies the hardware write lock to
 * the configuration register and drives the lock indicator.
 * Assumes an Avalon-MM master with waitrequest on the register side and a
 * switch bank that is synchronous to clk.
 */
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fbas_select #(
    parameter int RESTART_CYCLES = fbas_pkg::RESTART_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire fbas_pkg::fbas_switch_type sw,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [6:0] station_addr,
    output logic station_valid,
    output logic telegram_mode,
    output logic restart,
    output logic comm_enable,
    output logic lock_indicator,
    output logic [15:0] config_value
);

    // All state of the top in one record
    typedef struct packed {
        fbas_pkg::fbas_phase_type phase;
        logic [6:0] run_addr;
        logic run_tel;
        logic lock;
        logic simulating;
        logic comm;
        logic restart;
        logic [15:0] cfg;
        logic [1:0] flags;
        logic [31:0] rdata;
        logic wait_n;
        logic waitreq;
        logic valid;
    } fbas_top_type;

    fbas_top_type s_q;
    fbas_top_type s_d;

    logic [6:0] w_sw_addr;
    logic w_target_tel;
    logic w_change;
    logic w_ready;
    logic t_start;
    logic t_busy;
    logic t_done;

    logic req;
    logic commit;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic [6:0] cmd_addr;
    logic cmd_ok;

    fbas_watch u_watch (
        .clk(clk),
        .srst(srst),
        .sw(sw),
        .sw_addr(w_sw_addr),
        .target_tel(w_target_tel),
        .change(w_change),
        .ready(w_ready)
    );

    fbas_timer #(
        .CYCLES(RESTART_CYCLES)
    ) u_timer (
        .clk(clk),
        .srst(srst),
        .start(t_start),
        .busy(t_busy),
        .done(t_done)
    );

    // Bus handshake: one wait state, then the access commits
    assign req = avs_read || avs_write;
    assign commit = req && s_q.wait_n;

    // Restart delay starts, or starts over, on every relevant change
    assign t_start = w_change && (s_q.phase != fbas_pkg::PH_INIT);

    // Telegram request decode, only byte lane 0 carries the address
    assign cmd_addr = avs_writedata[6:0];
    assign cmd_ok = (s_q.phase == fbas_pkg::PH_RUN) && s_q.run_tel
        && !s_q.simulating && (cmd_addr <= fbas_pkg::ADDR_MAX_VALID);

    // Read data for the addressed register, unmapped reads give zero
    function automatic logic [31:0] read_mux(input logic [4:0] a, input fbas_top_type s,
        input fbas_pkg::fbas_switch_type b, input logic pend);
        logic [31:0] r;
        r = 32'h00000000;
        case (a)
            fbas_pkg::REG_STATUS:
            begin
                r[fbas_pkg::ST_TELEGRAM_BIT] = s.run_tel;
                r[fbas_pkg::ST_SIMULATION_BIT] = s.simulating;
                r[fbas_pkg::ST_LOCK_BIT] = s.lock;
                r[fbas_pkg::ST_PENDING_BIT] = pend;
                r[fbas_pkg::ST_COMM_BIT] = s.comm;
                r[fbas_pkg::ST_SW_ADDR_LSB +: fbas_pkg::ADDR_W] = b.addr;
                r[fbas_pkg::ST_SW_MODE_BIT] = b.telegram_mode;
            end
            fbas_pkg::REG_STATION:
            begin
                r[fbas_pkg::ADDR_W-1:0] = s.run_addr;
                r[fbas_pkg::STN_VALID_BIT] = (s.run_addr <= fbas_pkg::ADDR_MAX_VALID);
            end
            fbas_pkg::REG_CONFIG:
                r[fbas_pkg::CONFIG_W-1:0] = s.cfg;
            fbas_pkg::REG_FLAGS:
                r[fbas_pkg::FL_W-1:0] = s.flags;
            default:
                r = 32'h00000000;
        endcase
        return r;
    endfunction

    // Next state of the whole top
    always_comb
    begin
        s_d = s_q;
        flag_set = 2'b00;
        flag_clr = 2'b00;
        s_d.restart = 1'b0;

        // Waitrequest drops for exactly one cycle per access
        s_d.wait_n = req && !s_q.wait_n;
        s_d.waitreq = !s_d.wait_n;
        if (req && !s_q.wait_n)
            s_d.rdata = read_mux(avs_address, s_q, sw, t_busy);

        // Lock and simulation follow their switches directly
        s_d.lock = sw.write_lock;
        s_d.simulating = sw.simulation_switch;
        s_d.comm = !sw.simulation_switch;

        // Address phase machine
        case (s_q.phase)
            fbas_pkg::PH_INIT:
            begin
                // Power-up takes whatever the switches select
                if (w_ready)
                begin
                    s_d.run_tel = w_target_tel;
                    s_d.run_addr = w_target_tel ? fbas_pkg::ADDR_SERVICE : w_sw_addr;
                    s_d.phase = fbas_pkg::PH_RUN;
                end
            end
            fbas_pkg::PH_RUN:
            begin
                if (w_change)
                    s_d.phase = fbas_pkg::PH_WAIT;
            end
            fbas_pkg::PH_WAIT:
            begin
                // A change in the same cycle as expiry wins and waits again
                if (t_done && !w_change)
                begin
                    s_d.run_tel = w_target_tel;
                    s_d.run_addr = w_target_tel ? fbas_pkg::ADDR_SERVICE
                        : w_sw_addr;
                    s_d.restart = 1'b1;
                    s_d.phase = fbas_pkg::PH_RUN;
                end
            end
            default:
                s_d.phase = fbas_pkg::PH_INIT;
        endcase

        // Register writes take effect at the committing edge
        if (commit && avs_write)
        begin
            case (avs_address)
                fbas_pkg::REG_ADDR_CMD:
                begin
                    if (avs_byteenable[0] && cmd_ok)
                        s_d.run_addr = cmd_addr;
                    else
                        flag_set[fbas_pkg::FL_TEL_REFUSED_BIT] = 1'b1;
                end
                fbas_pkg::REG_CONFIG:
                begin
                    if (s_q.lock)
                        flag_set[fbas_pkg::FL_CFG_REFUSED_BIT] = 1'b1;
                    else
                    begin
                        if (avs_byteenable[0])
                            s_d.cfg[7:0] = avs_writedata[7:0];
                        if (avs_byteenable[1])
                            s_d.cfg[15:8] = avs_writedata[15:8];
                    end
                end
                fbas_pkg::REG_FLAGS:
                begin
                    if (avs_byteenable[0])
                        flag_clr = avs_writedata[fbas_pkg::FL_W-1:0];
                end
                default:
                    flag_clr = 2'b00;
            endcase
        end

        // Sticky flags: a new event beats a clear in the same cycle
        s_d.flags = (s_q.flags & ~flag_clr) | flag_set;

        // Registered so the output needs no decode of the phase
        s_d.valid = (s_d.phase != fbas_pkg::PH_INIT);
    end

    // Reset leaves the device as shipped: telegram mode at service address
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_q.phase <= fbas_pkg::PH_INIT;
            s_q.run_addr <= fbas_pkg::ADDR_SERVICE;
            s_q.run_tel <= 1'b1;
            s_q.lock <= 1'b0;
            s_q.simulating <= 1'b0;
            s_q.comm <= 1'b0;
            s_q.restart <= 1'b0;
            s_q.cfg <= fbas_pkg::CONFIG_RST;
            s_q.flags <= 2'b00;
            s_q.rdata <= 32'h00000000;
            s_q.wait_n <= 1'b0;
            s_q.waitreq <= 1'b1;
            s_q.valid <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    // Outputs straight from the state record
    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign station_addr = s_q.run_addr;
    assign station_valid = s_q.valid;
    assign telegram_mode = s_q.run_tel;
    assign restart = s_q.restart;
    assign comm_enable = s_q.comm;
    assign lock_indicator = s_q.lock;
    assign config_value = s_q.cfg;

endmodule
`default_nettype wire

// ===== test/fbas_checker.sv
/*
 * Port checker for the station address and write lock select block.
 * Assumes one clock, synchronous srst and a shortened restart delay.
 */
`timescale 1ns/1ps
`default_nettype none
module fbas_checker #(
    parameter int RESTART_CYCLES = 20
) (
    input wire logic clk,
    input wire logic srst,
    input wire fbas_pkg::fbas_switch_type sw,
    input wire logic [4:0] avs_address,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [6:0] station_addr,
    input wire logic telegram_mode,
    input wire logic restart,
    input wire logic comm_enable,
    input wire logic lock_indicator,
    input wire logic [15:0] config_value
);
    logic [6:0] pa_q;
    logic pm_q;
    logic pend_q;
    logic [31:0] quiet_q;
    logic [1:0] age_q;
    wire chg = (sw.telegram_mode != pm_q) || (!sw.telegram_mode && sw.addr != pa_q);
    wire cmit = avs_write && !avs_waitrequest;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // Quiet time since the last switch change that must lead to a restart
    always_ff @(posedge clk)
    begin
        pa_q <= sw.addr;
        pm_q <= sw.telegram_mode;
        if (srst)
        begin
            quiet_q <= 32'h0;
            pend_q <= 1'b0;
            age_q <= 2'h0;
        end
        else
        begin
            age_q <= age_q + {1'b0, age_q != 2'h3};
            quiet_q <= chg ? 32'h0 : quiet_q + {31'h0, quiet_q < 32'hFFFF};
            pend_q <= chg | (pend_q & ~restart);
        end
    end

    chk_lock_follow: assert property (!$past(srst) |-> lock_indicator == $past(sw.write_lock))
        else $error("lock indicator does not follow the lock switch");
    chk_comm_sim: assert property (!$past(srst) |-> comm_enable == !$past(sw.simulation_switch))
        else $error("comm enable does not follow the simulation switch");
    chk_cfg_locked: assert property (cmit && avs_address == fbas_pkg::REG_CONFIG && lock_indicator
        && sw.write_lock |=> $stable(config_value)) else $error("config written while locked");
    chk_cfg_cause: assert property (!$past(srst) && !$stable(config_value) |->
        $past(cmit && avs_address == fbas_pkg::REG_CONFIG)) else $error("config changed unasked");
    chk_restart_quiet: assert property (restart |-> pend_q && quiet_q >= RESTART_CYCLES)
        else $error("restart without a settled qualifying change");
    chk_restart_due: assert property (!(pend_q && quiet_q > RESTART_CYCLES + 8))
        else $error("restart overdue");
    chk_tel_default: assert property (restart && telegram_mode |-> station_addr == 7'h7E)
        else $error("telegram restart not at service address");
    chk_sw_adopt: assert property (restart && !telegram_mode |-> station_addr == sw.addr
        && sw.addr <= fbas_pkg::ADDR_MAX_VALID) else $error("switch address not adopted");
    chk_mode_pick: assert property (restart |-> telegram_mode ==
        (sw.telegram_mode || sw.addr > fbas_pkg::ADDR_MAX_VALID)) else $error("wrong mode");
    chk_addr_cause: assert property (age_q == 2'h3 && !$stable(station_addr) |-> restart ||
        $past(cmit && avs_address == fbas_pkg::REG_ADDR_CMD && telegram_mode))
        else $error("station address changed without cause");

    cov_tel_restart: cover property (restart && telegram_mode);
    cov_sw_restart: cover property (restart && !telegram_mode);
    cov_tel_write: cover property (cmit && avs_address == fbas_pkg::REG_ADDR_CMD && telegram_mode);
endmodule
bind fbas_select fbas_checker #(.RESTART_CYCLES(RESTART_CYCLES)) i_fbas_checker (.clk(clk),
    .srst(srst), .sw(sw), .avs_address(avs_address), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .station_addr(station_addr),
    .telegram_mode(telegram_mode), .restart(restart), .comm_enable(comm_enable),
    .lock_indicator(lock_indicator), .config_value(config_value));
`default_nettype wire

// ===== test/fbas_fieldbus_master.sv
/*
 * Behavioural fieldbus master: register traffic and address telegrams.
 * Assumes the slave answers with waitrequest low on the committing edge.
 */
`timescale 1ns/1ps
`default_nettype none
module fbas_fieldbus_master (
    input wire logic clk,
    input wire logic avs_waitrequest,
    output logic [4:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable
);
    initial
    begin
        avs_address = 5'h1F;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
    end

    // Released lines show inverted values so stale data never looks valid
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk);
        while (avs_waitrequest)
            @(posedge clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= ~d;
        avs_address <= ~a;
    endtask

    // Address assignment telegram, any 7-bit address, the block refuses above 125
    task automatic tel(input logic [6:0] a);
        xfer(1'b1, fbas_pkg::REG_ADDR_CMD, {25'h0, a});
    endtask
endmodule
`default_nettype wire

// ===== test/bus_address_and_write_lock_select_bench.sv
/*
 * Self-checking bench for the station address and write lock select block.
 * Assumes the restart delay is shortened to RC cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module bus_address_and_write_lock_select_bench;
    localparam int RC = 20;
    logic clk = 1'b0;
    logic srst = 1'b1;
    fbas_pkg::fbas_switch_type sw = {7'h31, 1'b1, 1'b0, 1'b0};
    logic [4:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, station_valid, telegram_mode, restart;
    logic comm_enable, lock_indicator;
    logic [31:0] avs_writedata, avs_readdata, seed = 32'h43A3;
    logic [3:0] avs_byteenable;
    logic [6:0] station_addr, t, v;
    logic [15:0] config_value;
    logic [31:0] rd_q[$], rs_q[$];
    int err_total = 0;
    int samples_checked = 0;

    always #12.5 clk = ~clk;

    fbas_select #(.RESTART_CYCLES(RC)) i_fbas_select (.clk(clk), .srst(srst), .sw(sw),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .station_addr(station_addr), .station_valid(station_valid),
        .telegram_mode(telegram_mode), .restart(restart), .comm_enable(comm_enable),
        .lock_indicator(lock_indicator), .config_value(config_value));
    fbas_fieldbus_master i_fbas_fieldbus_master (.clk(clk), .avs_waitrequest(avs_waitrequest),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        i_fbas_fieldbus_master.xfer(1'b0, a, 32'h0);
    endtask

    // Switch change, then an idle span long enough for any restart
    task automatic sws(input logic [6:0] a, input logic m, input logic s, input logic l);
        @(posedge clk);
        sw <= {a, m, s, l};
        repeat (RC + 20) @(posedge clk);
    endtask

    // Results are compared in the order they appear at the outputs
    always @(posedge clk)
    begin
        if (avs_read && !avs_waitrequest)
            check(avs_readdata, rd_q.size() ? rd_q.pop_front() : 32'hDEADBEEF);
        if (restart)
            check({24'h0, telegram_mode, station_addr}, rs_q.size() ? rs_q.pop_front() : 32'hF);
    end

    initial
    begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        rd(fbas_pkg::REG_STATION, 32'h7E);
        check({31'h0, station_valid}, 32'h1);
        seed = lfsr(seed);
        t = 7'(seed % 126);
        i_fbas_fieldbus_master.tel(t);
        rd(fbas_pkg::REG_STATION, {23'h0, 1'b1, 1'b0, t});
        sws(7'h05, 1'b1, 1'b0, 1'b0);
        rd(fbas_pkg::REG_STATION, {23'h0, 1'b1, 1'b0, t});
        rs_q.push_back(32'h31);
        sws(7'h31, 1'b0, 1'b0, 1'b0);
        i_fbas_fieldbus_master.tel(7'h05);
        rd(fbas_pkg::REG_STATION, 32'h131);
        rd(fbas_pkg::REG_FLAGS, 32'h1);
        i_fbas_fieldbus_master.xfer(1'b1, fbas_pkg::REG_FLAGS, 32'h3);
        rd(fbas_pkg::REG_FLAGS, 32'h0);
        seed = lfsr(seed);
        v = 7'(seed % 60);
        @(posedge clk);
        sw <= {v, 3'b000};
        repeat (5) @(posedge clk);
        rs_q.push_back({25'h0, v + 7'h3D});
        sws(v + 7'h3D, 1'b0, 1'b0, 1'b0);
        rs_q.push_back(32'hFE);
        sws(7'h7F, 1'b0, 1'b0, 1'b0);
        rs_q.push_back(32'h11);
        sws(7'h11, 1'b0, 1'b0, 1'b0);
        rs_q.push_back(32'hFE);
        sws(7'h11, 1'b1, 1'b0, 1'b0);
        seed = lfsr(seed);
        i_fbas_fieldbus_master.xfer(1'b1, fbas_pkg::REG_CONFIG, {16'h0, seed[15:0]});
        rd(fbas_pkg::REG_CONFIG, {16'h0, seed[15:0]});
        sws(7'h11, 1'b1, 1'b0, 1'b1);
        check({31'h0, lock_indicator}, 32'h1);
        i_fbas_fieldbus_master.xfer(1'b1, fbas_pkg::REG_CONFIG, ~seed);
        rd(fbas_pkg::REG_CONFIG, {16'h0, seed[15:0]});
        check({16'h0, config_value}, {16'h0, seed[15:0]});
        rd(fbas_pkg::REG_FLAGS, 32'h2);
        rd(fbas_pkg::REG_STATUS, 32'h9115);
        sws(7'h11, 1'b1, 1'b1, 1'b1);
        rd(fbas_pkg::REG_STATUS, 32'h9107);
        check({31'h0, comm_enable}, 32'h0);
        rd(5'h14, 32'h0);
        repeat (RC + 20) @(posedge clk);
        if (rd_q.size() || rs_q.size())
            err_total++;
        report_and_stop();
    end

    // Watchdog well beyond the expected run of some 430 cycles
    initial
    begin
        repeat (4000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
endmodule
`default_nettype wire
